// ==== verilog/tcc_core.sv ====
// Counter core of one 16-bit timer channel with five counting modes.
// Assumes the timer input pin is asynchronous and the controls come from same-clock logic.
`timescale 1ns/1ps
`default_nettype none
module tcc_core
	import tcc_pkg::*;
#(
	parameter int NUM_TAPS = 4
)(
	// Clock and reset.
	input  wire logic                        ref_clk,
	input  wire logic                        rst_n,
	// Channel configuration.
	input  wire logic [MODE_W-1:0]           channel_mode_reg,
	input  wire tcc_mode_t                   op_mode,
	input  wire logic                        count_source_sel,
	input  wire logic                        start_irq_mode_bit,
	input  wire logic                        filter_en,
	input  wire logic                        edge_rise_en,
	input  wire logic                        edge_fall_en,
	input  wire logic [NUM_TAPS*SEL_W-1:0]   prescaler_select,
	// Channel control.
	input  wire logic                        channel_start_bit,
	input  wire logic                        channel_stop_bit,
	input  wire logic                        data_wr_en,
	input  wire logic [CNT_W-1:0]            data_wr_val,
	// External pin.
	input  wire logic                        timer_input_pin,
	// Status and results.
	output logic                             channel_enabled_status,
	output logic [CNT_W-1:0]                 channel_counter,
	output logic [CNT_W-1:0]                 channel_data_reg,
	output logic                             channel_irq,
	output logic                             count_clock,
	output logic                             start_trig
);

	// ----------------------------------------------------------------------
	// Operation clock selection
	// ----------------------------------------------------------------------
	logic [OPSEL_W-1:0] op_sel;
	logic [SEL_W-1:0]   tap_sel;
	logic               channel_op_clock;

	// The two-bit field picks one of the prescaler taps for this channel.
	assign op_sel  = channel_mode_reg[OPSEL_HI_BIT:OPSEL_LO_BIT];
	assign tap_sel = prescaler_select[op_sel*SEL_W +: SEL_W];

	tcc_prescaler u_pre (
		.ref_clk      (ref_clk),
		.rst_n        (rst_n),
		.div_sel      (tap_sel),
		.div_pulse_ff (channel_op_clock)
	);

	// ----------------------------------------------------------------------
	// Pin synchroniser, filter and edge detection
	// ----------------------------------------------------------------------
	logic                   pin_s1_ff, pin_s2_ff;
	logic [FILT_STAGES-1:0] filt_ff, nxt_filt;
	logic                   samp_ff, nxt_samp;
	logic                   samp_d_ff, nxt_samp_d;
	logic                   rise_det, fall_det, edge_det;

	// Two flops before anything reads the pin; the first feeds only the second.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_ff <= 1'b0;
			pin_s2_ff <= 1'b0;
		end else begin
			pin_s1_ff <= timer_input_pin;
			pin_s2_ff <= pin_s1_ff;
		end
	end

	// Sample on op clock; the filter needs matching samples, adding two op periods.
	always_comb begin
		nxt_filt   = filt_ff;
		nxt_samp   = samp_ff;
		nxt_samp_d = samp_d_ff;
		if (channel_op_clock) begin
			nxt_filt   = {filt_ff[FILT_STAGES-2:0], pin_s2_ff};
			nxt_samp_d = samp_ff;
			if (!filter_en)
				nxt_samp = pin_s2_ff;
			else if (&{filt_ff, pin_s2_ff} || ~|{filt_ff, pin_s2_ff})
				nxt_samp = pin_s2_ff;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			filt_ff   <= '0;
			samp_ff   <= 1'b0;
			samp_d_ff <= 1'b0;
		end else begin
			filt_ff   <= nxt_filt;
			samp_ff   <= nxt_samp;
			samp_d_ff <= nxt_samp_d;
		end
	end

	// Edges are looked at once per op clock so each yields a single pulse.
	assign rise_det = channel_op_clock && samp_ff && !samp_d_ff;
	assign fall_det = channel_op_clock && !samp_ff && samp_d_ff;
	assign edge_det = (rise_det && edge_rise_en) || (fall_det && edge_fall_en);

	// ----------------------------------------------------------------------
	// Channel state machine and counter
	// ----------------------------------------------------------------------
	tcc_state_t       state_ff, nxt_state;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [CNT_W-1:0] data_ff, nxt_data;
	logic             irq_ff, nxt_irq;
	logic             tclk_ff, nxt_tclk;
	logic             trig_ff, nxt_trig;
	logic             tclk;
	logic             one_cnt_mode;

	// Count clock source select; a pulse here is registered into tclk_ff, which drives the counter on the edge after.
	assign tclk = count_source_sel ? edge_det : channel_op_clock;
	assign one_cnt_mode = (op_mode == TCC_ONE_COUNT) || (op_mode == TCC_CAP_ONECNT);

	// Next-state logic for all modes; the counter acts on the registered count clock.
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_data  = data_wr_en ? data_wr_val : data_ff;
		nxt_irq   = 1'b0;
		nxt_trig  = 1'b0;
		nxt_tclk  = tclk && (state_ff != TCC_ST_IDLE);
		unique case (state_ff)
			TCC_ST_IDLE: begin
				if (channel_start_bit) begin
					nxt_state = TCC_ST_WAIT;
					if (op_mode == TCC_EVENT) begin
						nxt_cnt   = data_ff;
						nxt_state = TCC_ST_COUNT;
					end else if (one_cnt_mode) begin
						nxt_state = TCC_ST_WAIT;
					end
				end
			end
			TCC_ST_WAIT: begin
				// Interval and capture start on the first count clock.
				if (!one_cnt_mode && tclk_ff) begin
					nxt_trig  = 1'b1;
					nxt_irq   = start_irq_mode_bit;
					nxt_state = TCC_ST_COUNT;
					nxt_cnt   = (op_mode == TCC_CAPTURE) ? CNT_ZERO : data_ff;
				end else if (one_cnt_mode && rise_det) begin
					nxt_trig  = 1'b1;
					nxt_irq   = start_irq_mode_bit;
					nxt_state = TCC_ST_COUNT;
					nxt_cnt   = (op_mode == TCC_CAP_ONECNT) ? CNT_ZERO : data_ff;
				end
			end
			TCC_ST_COUNT: begin
				unique case (op_mode)
					TCC_INTERVAL: if (tclk_ff) begin
						if (cnt_ff == CNT_ZERO) begin
							nxt_irq = 1'b1;
							nxt_cnt = data_ff;
						end else
							nxt_cnt = cnt_ff - 16'h0001;
					end
					TCC_EVENT: if (tclk_ff) begin
						if (cnt_ff == CNT_ZERO) begin
							nxt_irq = 1'b1;
							nxt_cnt = data_ff;
						end else
							nxt_cnt = cnt_ff - 16'h0001;
					end
					TCC_CAPTURE: begin
						if (edge_det) begin
							nxt_data = cnt_ff;
							nxt_irq  = 1'b1;
							nxt_cnt  = CNT_ZERO;
						end else if (tclk_ff)
							nxt_cnt = cnt_ff + 16'h0001;
					end
					TCC_ONE_COUNT: if (tclk_ff) begin
						if (cnt_ff == CNT_ZERO) begin
							nxt_irq   = 1'b1;
							nxt_cnt   = CNT_ALL1;
							nxt_state = TCC_ST_WAIT;
						end else
							nxt_cnt = cnt_ff - 16'h0001;
					end
					TCC_CAP_ONECNT: begin
						if (fall_det) begin
							nxt_data  = cnt_ff;
							nxt_irq   = 1'b1;
							nxt_state = TCC_ST_WAIT;
						end else if (tclk_ff)
							nxt_cnt = cnt_ff + 16'h0001;
					end
					default: nxt_state = TCC_ST_IDLE;
				endcase
			end
			default: nxt_state = TCC_ST_IDLE;
		endcase
		// Stop has priority over any start in the same cycle; a trigger meeting it is dropped.
		if (channel_stop_bit) begin
			nxt_state = TCC_ST_IDLE;
			nxt_trig  = 1'b0;
		end
	end

	// Registers only; every output except channel_enabled_status comes from here.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= TCC_ST_IDLE;
			cnt_ff   <= CNT_ZERO;
			data_ff  <= CNT_ZERO;
			irq_ff   <= 1'b0;
			tclk_ff  <= 1'b0;
			trig_ff  <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			data_ff  <= nxt_data;
			irq_ff   <= nxt_irq;
			tclk_ff  <= nxt_tclk;
			trig_ff  <= nxt_trig;
		end
	end

	// ----------------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------------
	logic en_ff;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			en_ff <= 1'b0;
		else
			en_ff <= (nxt_state != TCC_ST_IDLE);
	end

	assign channel_enabled_status = en_ff;
	assign channel_counter        = cnt_ff;
	assign channel_data_reg       = data_ff;
	assign channel_irq            = irq_ff;
	assign count_clock            = tclk_ff;
	assign start_trig             = trig_ff;

endmodule : tcc_core
`default_nettype wire

// ==== verilog/tcc_pkg.sv ====
// Package for the timer channel counter core: modes, field positions and constants.
// Assumes a single system clock domain; no register bus, all controls are ports.
package tcc_pkg;

	// ----------------------------------------------------------------------
	// Counter widths and fixed values
	// ----------------------------------------------------------------------
	localparam int          CNT_W      = 16;
	localparam logic [15:0] CNT_ZERO   = 16'h0000;
	localparam logic [15:0] CNT_ALL1   = 16'hffff;
	localparam int          PRE_W      = 15;       // System clock divided down to 2^15.
	localparam int          SEL_W      = 4;        // Prescaler tap index width.

	// ----------------------------------------------------------------------
	// Mode register field positions
	// ----------------------------------------------------------------------
	localparam int MODE_W       = 16;
	localparam int OPSEL_HI_BIT = 15;
	localparam int OPSEL_LO_BIT = 14;
	localparam int OPSEL_W      = 2;

	// ----------------------------------------------------------------------
	// Noise filter and synchroniser depths
	// ----------------------------------------------------------------------
	localparam int SYNC_STAGES  = 2;
	localparam int FILT_STAGES  = 2;           // Extra op-clock samples when filter on.

	// ----------------------------------------------------------------------
	// Operation modes
	// ----------------------------------------------------------------------
	typedef enum logic [2:0] {
		TCC_INTERVAL   = 3'h0,
		TCC_EVENT      = 3'h1,
		TCC_CAPTURE    = 3'h2,
		TCC_ONE_COUNT  = 3'h3,
		TCC_CAP_ONECNT = 3'h4
	} tcc_mode_t;

	// Channel run states.
	typedef enum logic [1:0] {
		TCC_ST_IDLE  = 2'h0,
		TCC_ST_WAIT  = 2'h1,
		TCC_ST_COUNT = 2'h2
	} tcc_state_t;

endpackage : tcc_pkg

// ==== verilog/tcc_prescaler.sv ====
// Free-running prescaler producing one-cycle pulses at system clock / 2^sel; sel 0 holds the output high.
// Assumes the select input is static or changes only while the channel is stopped.
`timescale 1ns/1ps
`default_nettype none
module tcc_prescaler
	import tcc_pkg::*;
(
	// Clock and reset.
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	// Tap select and pulse out.
	input  wire logic [SEL_W-1:0] div_sel,
	output logic                  div_pulse_ff
);

	// ----------------------------------------------------------------------
	// Divider counter and pulse
	// ----------------------------------------------------------------------
	logic [PRE_W-1:0] div_cnt_ff;
	logic [PRE_W-1:0] nxt_div_cnt;
	logic             nxt_div_pulse;
	logic [PRE_W-1:0] div_mask;

	// Pulse fires when all low bits below the tap wrap to zero; sel 0 stays high.
	always_comb begin
		nxt_div_cnt   = div_cnt_ff + {{(PRE_W-1){1'b0}}, 1'b1};
		div_mask      = PRE_W'((1 << div_sel) - 1);
		nxt_div_pulse = ((nxt_div_cnt & div_mask) == '0);
	end

	// Registers only.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_ff   <= '0;
			div_pulse_ff <= 1'b0;
		end else begin
			div_cnt_ff   <= nxt_div_cnt;
			div_pulse_ff <= nxt_div_pulse;
		end
	end

endmodule : tcc_prescaler
`default_nettype wire

// ==== verif/tcc_checker.sv ====
// Concurrent checks on the ports of the timer channel counter core.
// Assumes a bind from the bench top and the single system clock domain.
`timescale 1ns/1ps
`default_nettype none
module tcc_checker
	import tcc_pkg::*;
#(
	parameter int NUM_TAPS = 4
)(
	// Clock and reset.
	input wire logic             ref_clk,
	input wire logic             rst_n,
	// Controls.
	input wire tcc_mode_t        op_mode,
	input wire logic [MODE_W-1:0] channel_mode_reg,
	input wire logic             count_source_sel,
	input wire logic [NUM_TAPS*SEL_W-1:0] prescaler_select,
	input wire logic             start_irq_mode_bit,
	input wire logic             channel_start_bit,
	input wire logic             channel_stop_bit,
	// Results.
	input wire logic             channel_enabled_status,
	input wire logic [CNT_W-1:0] channel_counter,
	input wire logic [CNT_W-1:0] channel_data_reg,
	input wire logic             channel_irq,
	input wire logic             count_clock,
	input wire logic             start_trig
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	// One clock domain, so clock and reset are given once.
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// A start that the idle channel must take; stop wins over start.
	wire logic idle_start = channel_start_bit && !channel_stop_bit && !channel_enabled_status;
	// Divide exponent of the tap that feeds this channel; zero means the clock stands high.
	wire logic [SEL_W-1:0] tap_exp =
		prescaler_select[channel_mode_reg[OPSEL_HI_BIT:OPSEL_LO_BIT]*SEL_W +: SEL_W];
	wire logic undivided = !count_source_sel && (tap_exp == '0);

	irq_pulse_a: assert property (channel_irq |=> !channel_irq)
		else $error("interrupt longer than one cycle");
	cc_pulse_a: assert property (count_clock && !undivided |=> !count_clock)
		else $error("count clock longer than one cycle");
	undiv_high_a: assert property (undivided && channel_enabled_status ##1 channel_enabled_status |-> count_clock)
		else $error("undivided count clock not held high");
	start_en_a: assert property (idle_start |=> channel_enabled_status)
		else $error("start not taken");
	event_load_a: assert property (idle_start && op_mode == TCC_EVENT |=> channel_counter == channel_data_reg)
		else $error("event start did not load data");
	stop_hold_a: assert property (!channel_enabled_status ##1 !channel_enabled_status |-> $stable(channel_counter))
		else $error("counter moved while stopped");
	start_irq_a: assert property (start_trig |-> channel_enabled_status && (!start_irq_mode_bit || channel_irq))
		else $error("no interrupt at start trigger");
	count_dn_a: assert property (op_mode == TCC_INTERVAL && count_clock |=> !channel_enabled_status || start_trig || channel_irq || channel_counter == $past(channel_counter) - 16'h0001)
		else $error("interval counter did not step down");
	reload_a: assert property (op_mode == TCC_INTERVAL && channel_irq && !start_trig |-> channel_counter == channel_data_reg && $past(channel_counter) == CNT_ZERO)
		else $error("interval reload wrong");
	capture_a: assert property (op_mode == TCC_CAPTURE && channel_irq && !start_trig |-> channel_counter == CNT_ZERO && channel_data_reg == $past(channel_counter))
		else $error("capture wrong");
	one_end_a: assert property (op_mode == TCC_ONE_COUNT && channel_irq && !start_trig |-> channel_counter == CNT_ALL1 ##1 channel_counter == CNT_ALL1)
		else $error("one-count end wrong");
	zero_load_a: assert property ((op_mode == TCC_CAPTURE || op_mode == TCC_CAP_ONECNT) && start_trig |-> channel_counter == CNT_ZERO)
		else $error("capture start did not clear");
	// Main scenarios reached.
	cover property (start_trig && channel_irq);
	cover property (op_mode == TCC_CAPTURE && channel_irq);
	cover property (op_mode == TCC_ONE_COUNT && channel_irq);
endmodule : tcc_checker
`default_nettype wire

// ==== verif/tcc_pin_model.sv ====
// Behavioural source of the signal on the timer input pin.
// Assumes the bench calls its task; the pin rests low between pulses.
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
	// Pin toward the channel.
	output logic timer_input_pin
);
	// Levels change with no regard to the system clock, as a real pin does.
	initial timer_input_pin = 1'h0;
	// Sends n high pulses; widths are in nanoseconds.
	// The first step is 1 ns so no level change lands in the time step of a clock edge.
	task pulse(input int n, input int hi, input int lo);
		#1;
		repeat (n) begin
			timer_input_pin = 1'h1;
			#hi;
			timer_input_pin = 1'h0;
			#lo;
		end
	endtask : pulse
endmodule : tcc_pin_model
`default_nettype wire

// ==== verif/tcc_core_tb.sv ====
// Self-checking bench for the timer channel counter core.
// Assumes the package, core, pin model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tcc_core_tb
	import tcc_pkg::*;
;
	// ----------------------------------------
	// Stimulus and wiring
	// ----------------------------------------
	logic        ref_clk = 1'h0, rst_n = 1'h0, count_source_sel = 1'h0;
	logic [15:0] channel_mode_reg = 16'h0000, prescaler_select = 16'h0000;
	logic [15:0] data_wr_val = 16'h0000;
	tcc_mode_t   op_mode = TCC_INTERVAL;
	logic        start_irq_mode_bit = 1'h0, filter_en = 1'h0, edge_rise_en = 1'h1;
	logic        edge_fall_en = 1'h0, channel_start_bit = 1'h0, channel_stop_bit = 1'h0;
	logic        data_wr_en = 1'h0;
	wire logic   timer_input_pin, channel_enabled_status, channel_irq, count_clock, start_trig;
	wire logic [15:0] channel_counter, channel_data_reg;
	int          n_mismatch = 0, tests_run = 0;

	tcc_core uut (.ref_clk, .rst_n, .channel_mode_reg, .op_mode, .count_source_sel,
		.start_irq_mode_bit, .filter_en, .edge_rise_en, .edge_fall_en, .prescaler_select,
		.channel_start_bit, .channel_stop_bit, .data_wr_en, .data_wr_val, .timer_input_pin,
		.channel_enabled_status, .channel_counter, .channel_data_reg, .channel_irq,
		.count_clock, .start_trig);
	tcc_pin_model far (.timer_input_pin);

	// System clock at 50 MHz.
	always #10 ref_clk = ~ref_clk;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task results();
		$display("mismatches %0d of %0d checks", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Counts edges until the interrupt (w 0) or count clock (w 1); a hang ends the run.
	task wt(input int w, output int n);
		for (n = 1; n < 400; n++) begin
			@(posedge ref_clk);
			#1;
			if ((w == 0 ? channel_irq : count_clock) === 1'h1)
				return;
		end
		n_mismatch++;
		results();
	endtask : wt

	// One-cycle start (s 1) or stop (s 0) request.
	task kick(input logic s);
		@(posedge ref_clk);
		channel_start_bit <= s;
		channel_stop_bit <= !s;
		@(posedge ref_clk);
		channel_start_bit <= 1'h0;
		channel_stop_bit <= 1'h0;
	endtask : kick

	// Mode set-up and data write, only while the channel is stopped.
	task cfg(input tcc_mode_t m, input logic src, input logic [15:0] d, input logic im);
		@(posedge ref_clk);
		op_mode <= m;
		count_source_sel <= src;
		start_irq_mode_bit <= im;
		edge_fall_en <= (m == TCC_CAP_ONECNT);
		filter_en <= 1'h0;
		data_wr_en <= 1'h1;
		data_wr_val <= d;
		@(posedge ref_clk);
		data_wr_en <= 1'h0;
	endtask : cfg

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_interval();
		int n;
		cfg(TCC_INTERVAL, 1'h0, 16'h0005, 1'h1);
		kick(1'h1);
		wt(0, n);
		chk(start_trig, 16'h0001);
		chk(channel_counter, 16'h0005);
		wt(0, n);
		chk(n[15:0], 16'h0006);
		chk(channel_counter, 16'h0005);
		kick(1'h0);
		#1;
		chk(channel_enabled_status, 16'h0000);
	endtask : t_interval

	// Tap 1 divides by 4 and is picked by the top two mode bits.
	task t_divided();
		int n;
		@(posedge ref_clk);
		channel_mode_reg <= 16'h4000;
		prescaler_select <= 16'h0020;
		cfg(TCC_INTERVAL, 1'h0, 16'h0100, 1'h0);
		kick(1'h1);
		wt(1, n);
		wt(1, n);
		chk(n[15:0], 16'h0004);
		kick(1'h0);
		// Later scenarios count in system clocks, so the undivided tap is restored.
		channel_mode_reg <= 16'h0000;
		prescaler_select <= 16'h0000;
	endtask : t_divided

	task t_event();
		int lag [2];
		cfg(TCC_EVENT, 1'h1, 16'h0003, 1'h0);
		kick(1'h1);
		#1;
		chk(channel_counter, 16'h0003);
		far.pulse(2, 200, 200);
		chk(channel_counter, 16'h0001);
		foreach (lag[f]) begin
			@(posedge ref_clk);
			filter_en <= f[0];
			#1;
			fork
				far.pulse(1, 200, 200);
				wt(1, lag[f]);
			join
		end
		chk(lag[1][15:0] - lag[0][15:0], 16'h0002);
		kick(1'h0);
	endtask : t_event

	// Rising edges 10 cycles apart; the second capture holds 9, as the counter restarts from zero the cycle after a capture.
	task t_capture();
		int n;
		cfg(TCC_CAPTURE, 1'h0, 16'h0000, 1'h0);
		kick(1'h1);
		fork
			far.pulse(2, 100, 100);
			begin
				wt(0, n);
				wt(0, n);
			end
		join
		chk(channel_data_reg, 16'h0009);
		kick(1'h0);
	endtask : t_capture

	task t_onecount();
		int n;
		cfg(TCC_ONE_COUNT, 1'h0, 16'h0004, 1'h0);
		kick(1'h1);
		fork
			far.pulse(1, 100, 100);
			wt(0, n);
		join
		chk(channel_counter, 16'hffff);
		repeat (3) @(posedge ref_clk);
		#1;
		chk(channel_counter, 16'hffff);
		chk(channel_enabled_status, 16'h0001);
		kick(1'h0);
	endtask : t_onecount

	// A 15-cycle high level captures 14, as the counter starts from zero the cycle after the rise; the check accepts 14 or 15.
	task t_hiwidth();
		int n;
		cfg(TCC_CAP_ONECNT, 1'h0, 16'h0000, 1'h0);
		kick(1'h1);
		fork
			far.pulse(1, 300, 100);
			wt(0, n);
		join
		chk({15'h0000, channel_data_reg > 16'h000d && channel_data_reg < 16'h0010}, 16'h0001);
		kick(1'h0);
	endtask : t_hiwidth

	// Reset for 10 cycles, then every scenario in turn.
	initial begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'h1;
		t_interval();
		t_divided();
		t_event();
		t_capture();
		t_onecount();
		t_hiwidth();
		results();
	end
endmodule : tcc_core_tb

bind tcc_core tcc_checker #(.NUM_TAPS(NUM_TAPS)) chk_i (.ref_clk, .rst_n, .op_mode,
	.channel_mode_reg, .count_source_sel, .prescaler_select, .start_irq_mode_bit,
	.channel_start_bit, .channel_stop_bit, .channel_enabled_status, .channel_counter,
	.channel_data_reg, .channel_irq, .count_clock, .start_trig);
`default_nettype wire
